// ==== design/led_port_pkg.sv ====
// constants shared by the led driver serial register port
package led_port_pkg;

   // ------------------------------------------------------------
   // serial address and register map
   // ------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR = 7'h36;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int NUM_REGS = 6;
   localparam int IDX_GENERAL = 0;
   localparam int IDX_RAMP = 1;
   localparam int IDX_HEADROOM = 2;
   localparam int IDX_MAIN = 3;
   localparam int IDX_AUX = 4;
   localparam int IDX_IND = 5;
   localparam logic [7:0] REG_OFS [NUM_REGS] = '{8'h10, 8'h20, 8'h60, 8'ha0, 8'hb0, 8'hc0};
   localparam logic [7:0] REG_RST [NUM_REGS] = '{8'h00, 8'hf0, 8'hfc, 8'he0, 8'hf8, 8'hf8};
   // writable bits; all others hold their reset value
   localparam logic [7:0] REG_WMASK [NUM_REGS] = '{8'h7f, 8'h03, 8'h03, 8'h1f, 8'h07, 8'h07};

   // ------------------------------------------------------------
   // general configuration fields and level widths
   // ------------------------------------------------------------
   localparam int BIT_MAIN_ON = 0;
   localparam int BIT_AUX_ON = 1;
   localparam int BIT_IND_ON = 2;
   localparam int BIT_ONE_OFF = 3;
   localparam int BIT_TWO_OFF = 4;
   localparam int BIT_ONE_TO_MAIN = 5;
   localparam int BIT_TWO_TO_MAIN = 6;
   localparam int MAIN_LVL_W = 5;
   localparam int AUX_LVL_W = 3;
   localparam int SEL_W = 2;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_NS = 50;
   localparam int TMR_W = 21;
   localparam int RAMP_T0_NS = 100_000;
   localparam int RAMP_T1_NS = 25_000_000;
   localparam int RAMP_T2_NS = 50_000_000;
   localparam int RAMP_T3_NS = 100_000_000;
   localparam int RAMP_C0 = RAMP_T0_NS / CLK_NS;
   // least persistence of each delay range, rounded up
   localparam int HDR_T0_NS = 3_000_000;
   localparam int HDR_T1_NS = 1_500_000;
   localparam int HDR_T2_NS = 400_000;
   localparam int HDR_T3_NS = 60_000;
   localparam int HDR_C3 = (HDR_T3_NS + CLK_NS - 1) / CLK_NS;

   // ------------------------------------------------------------
   // serial slave states
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_RECV = 4'b0010,
      ST_ACK = 4'b0100,
      ST_IGNORE = 4'b1000
   } slave_state_e;

endpackage : led_port_pkg

// ==== design/led_reg_port.sv ====
// serial register port and sink control of the led driver
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - start: data falls while clock high
// - stop: data rises while clock high
// - bus busy from start until stop
// - repeated start restarts address reception
// - eight bits, msb first, then acknowledge slot
// - slave pulls data low through ninth pulse
// - first byte: seven-bit address, direction bit
// - answer address 36h only
// - second byte selects register, third writes
// - general config at 10h, resets zero
// - bits 2..0 enable indicator, aux, main
// - bits 3,4 shut shared sinks down
// - bits 5,6 attach shared sinks to main
// - cleared assignment puts shared sink in aux
// - main level at a0h, five bits
// - aux level at b0h, three bits
// - indicator level at c0h, three bits
// - ramp step 20h and headroom delay 60h
// - ramp step code picks step interval
// - delay code picks headroom shortfall persistence
// - hardware pin low resets registers, outputs off
module led_reg_port #(
   parameter int RAMP_STEP1_CYC = led_port_pkg::RAMP_T1_NS / led_port_pkg::CLK_NS,
   parameter int RAMP_STEP2_CYC = led_port_pkg::RAMP_T2_NS / led_port_pkg::CLK_NS,
   parameter int RAMP_STEP3_CYC = led_port_pkg::RAMP_T3_NS / led_port_pkg::CLK_NS,
   parameter int HDR_DELAY0_CYC = (led_port_pkg::HDR_T0_NS + led_port_pkg::CLK_NS - 1) / led_port_pkg::CLK_NS,
   parameter int HDR_DELAY1_CYC = (led_port_pkg::HDR_T1_NS + led_port_pkg::CLK_NS - 1) / led_port_pkg::CLK_NS,
   parameter int HDR_DELAY2_CYC = (led_port_pkg::HDR_T2_NS + led_port_pkg::CLK_NS - 1) / led_port_pkg::CLK_NS
) (
   input wire logic clk_i,                       // 20 MHz clock
   input wire logic reset_i,                     // async reset, high
   input wire logic hardware_reset_pin_i,        // low resets and disables
   input wire logic scl_i,                       // serial clock pin
   input wire logic sda_i,                       // serial data pin level
   output logic sda_o,                           // serial data drive value
   output logic sda_oe_o,                        // serial data drive enable
   input wire logic headroom_low_i,              // sink headroom shortfall
   output logic gain_boost_o,                    // request higher pump gain
   output logic main_sinks_on_o,                 // main group sinks on
   output logic [led_port_pkg::MAIN_LVL_W-1:0] main_level_o, // main level
   output logic aux_sinks_on_o,                  // aux group sinks on
   output logic [led_port_pkg::AUX_LVL_W-1:0] aux_level_o, // aux level
   output logic indicator_sink_on_o,             // indicator sink on
   output logic [led_port_pkg::AUX_LVL_W-1:0] indicator_level_o, // indicator level
   output logic shared_sink_one_on_o,            // first shared sink on
   output logic shared_sink_one_main_o,          // first shared sink in main
   output logic shared_sink_two_on_o,            // second shared sink on
   output logic shared_sink_two_main_o           // second shared sink in main
);

   localparam int TW = led_port_pkg::TMR_W;

   // ------------------------------------------------------------
   // parameter checks
   // ------------------------------------------------------------
   if (RAMP_STEP1_CYC < 1 || RAMP_STEP2_CYC < 1 || RAMP_STEP3_CYC < 1 ||
       HDR_DELAY0_CYC < 1 || HDR_DELAY1_CYC < 1 || HDR_DELAY2_CYC < 1 ||
       RAMP_STEP3_CYC >= 2**TW || HDR_DELAY0_CYC >= 2**TW) begin : bad_count
      $error("cycle counts must lie between 1 and the timer range");
   end

   // ------------------------------------------------------------
   // pin synchronisers and edge detection
   // ------------------------------------------------------------
   logic [3:0] meta_q;
   logic [3:0] sync_q;
   logic scl_p_q;
   logic sda_p_q;
   wire logic scl_s = sync_q[0];
   wire logic sda_s = sync_q[1];
   wire logic run_s = sync_q[2];
   wire logic hdr_s = sync_q[3];

   // two flops per pin
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_q <= 4'h3;
         sync_q <= 4'h3;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         meta_q <= {headroom_low_i, hardware_reset_pin_i, sda_i, scl_i};
         sync_q <= meta_q;
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   wire logic scl_rise = scl_s & ~scl_p_q;
   wire logic scl_fall = ~scl_s & scl_p_q;
   wire logic start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
   wire logic stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // ------------------------------------------------------------
   // serial slave
   // ------------------------------------------------------------
   led_port_pkg::slave_state_e state_q;
   led_port_pkg::slave_state_e state_d;
   logic [3:0] bit_cnt_q;
   logic [3:0] bit_cnt_d;
   logic [7:0] shift_q;
   logic [1:0] byte_idx_q;
   logic [1:0] byte_idx_d;
   logic [7:0] sel_q;
   logic ack_q;
   logic ack_d;
   logic [7:0] regs_q [led_port_pkg::NUM_REGS];

   wire logic byte_done = scl_fall && (bit_cnt_q == led_port_pkg::BITS_PER_BYTE);
   wire logic addr_hit = (shift_q[7:1] == led_port_pkg::DEV_ADDR);
   wire logic addr_wr = addr_hit & ~shift_q[0];
   wire logic ack_end = (state_q == led_port_pkg::ST_ACK) && scl_fall;
   wire logic wr_fire = ack_end && (byte_idx_q == 2'h2);

   // next state of the slave
   always_comb begin
      state_d = state_q;
      bit_cnt_d = bit_cnt_q;
      byte_idx_d = byte_idx_q;
      ack_d = ack_q;
      if (!run_s || stop_det) begin
         state_d = led_port_pkg::ST_IDLE;
         ack_d = 1'b0;
      end else if (start_det) begin
         state_d = led_port_pkg::ST_RECV;
         bit_cnt_d = '0;
         byte_idx_d = '0;
         ack_d = 1'b0;
      end else begin
         unique case (state_q)
            led_port_pkg::ST_IDLE,
            led_port_pkg::ST_IGNORE: begin
            end
            led_port_pkg::ST_RECV: begin
               if (scl_rise) begin
                  bit_cnt_d = bit_cnt_q + 4'h1;
               end else if (byte_done) begin
                  state_d = led_port_pkg::ST_ACK;
                  ack_d = (byte_idx_q != 2'h0) || addr_hit;
               end
            end
            led_port_pkg::ST_ACK: begin
               if (scl_fall) begin
                  ack_d = 1'b0;
                  bit_cnt_d = '0;
                  // read transfers are not served past the address
                  state_d = (byte_idx_q == 2'h0 && !addr_wr) ? led_port_pkg::ST_IGNORE
                          : led_port_pkg::ST_RECV;
                  byte_idx_d = (byte_idx_q == 2'h2) ? 2'h2 : byte_idx_q + 2'h1;
               end
            end
         endcase
      end
   end

   // slave state registers
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= led_port_pkg::ST_IDLE;
         bit_cnt_q <= '0;
         byte_idx_q <= '0;
         ack_q <= 1'b0;
      end else begin
         state_q <= state_d;
         bit_cnt_q <= bit_cnt_d;
         byte_idx_q <= byte_idx_d;
         ack_q <= ack_d;
      end
   end

   // msb-first shift and register select capture
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         shift_q <= '0;
         sel_q <= '0;
      end else begin
         if (state_q == led_port_pkg::ST_RECV && scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
         end
         if (ack_end && byte_idx_q == 2'h1) begin
            sel_q <= shift_q;
         end
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = ack_q;

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   for (genvar i = 0; i < led_port_pkg::NUM_REGS; i++) begin : g_reg
      wire logic hit = wr_fire && (sel_q == led_port_pkg::REG_OFS[i]);
      wire logic [7:0] wr_val = (shift_q & led_port_pkg::REG_WMASK[i]) |
                                (led_port_pkg::REG_RST[i] & ~led_port_pkg::REG_WMASK[i]);

      // write after acknowledge, pin low restores power-on value
      always_ff @(posedge clk_i or posedge reset_i) begin
         if (reset_i) begin
            regs_q[i] <= led_port_pkg::REG_RST[i];
         end else if (!run_s) begin
            regs_q[i] <= led_port_pkg::REG_RST[i];
         end else if (hit) begin
            regs_q[i] <= wr_val;
         end
      end

      fixed_bits_a: assert property (
         @(posedge clk_i) disable iff (reset_i)
         (regs_q[i] & ~led_port_pkg::REG_WMASK[i]) == (led_port_pkg::REG_RST[i] & ~led_port_pkg::REG_WMASK[i]))
         else $error("fixed register bits changed");
   end

   wire logic [7:0] gen = regs_q[led_port_pkg::IDX_GENERAL];
   wire logic [led_port_pkg::SEL_W-1:0] ramp_sel = regs_q[led_port_pkg::IDX_RAMP][led_port_pkg::SEL_W-1:0];
   wire logic [led_port_pkg::SEL_W-1:0] hdr_sel = regs_q[led_port_pkg::IDX_HEADROOM][led_port_pkg::SEL_W-1:0];

   // ------------------------------------------------------------
   // main group ramp
   // ------------------------------------------------------------
   wire logic main_active;
   wire logic [TW-1:0] step_cyc = (ramp_sel == 2'h0) ? TW'(led_port_pkg::RAMP_C0)
                                : (ramp_sel == 2'h1) ? TW'(RAMP_STEP1_CYC)
                                : (ramp_sel == 2'h2) ? TW'(RAMP_STEP2_CYC)
                                : TW'(RAMP_STEP3_CYC);

   level_ramp #(
      .LEVEL_W(led_port_pkg::MAIN_LVL_W),
      .CNT_W(TW)
   ) u_ramp (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .clear_i(!run_s),
      .enable_i(gen[led_port_pkg::BIT_MAIN_ON]),
      .target_i(regs_q[led_port_pkg::IDX_MAIN][led_port_pkg::MAIN_LVL_W-1:0]),
      .step_cycles_i(step_cyc),
      .level_o(main_level_o),
      .active_o(main_active)
   );

   // ------------------------------------------------------------
   // sink enables
   // ------------------------------------------------------------
   logic main_on_q;
   logic aux_on_q;
   logic ind_on_q;
   logic one_on_q;
   logic two_on_q;
   wire logic main_on_d = run_s & main_active;
   wire logic aux_on_d = run_s & gen[led_port_pkg::BIT_AUX_ON];
   wire logic ind_on_d = run_s & gen[led_port_pkg::BIT_IND_ON];
   // shared sinks follow main when attached, aux otherwise
   wire logic one_on_d = ~gen[led_port_pkg::BIT_ONE_OFF] &
                         (gen[led_port_pkg::BIT_ONE_TO_MAIN] ? main_on_d : aux_on_d);
   wire logic two_on_d = ~gen[led_port_pkg::BIT_TWO_OFF] &
                         (gen[led_port_pkg::BIT_TWO_TO_MAIN] ? main_on_d : aux_on_d);

   // registered enables
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         {main_on_q, aux_on_q, ind_on_q, one_on_q, two_on_q} <= '0;
      end else begin
         {main_on_q, aux_on_q, ind_on_q, one_on_q, two_on_q} <= {main_on_d, aux_on_d, ind_on_d, one_on_d, two_on_d};
      end
   end

   assign main_sinks_on_o = main_on_q;
   assign aux_sinks_on_o = aux_on_q;
   assign indicator_sink_on_o = ind_on_q;
   assign shared_sink_one_on_o = one_on_q;
   assign shared_sink_two_on_o = two_on_q;
   assign shared_sink_one_main_o = gen[led_port_pkg::BIT_ONE_TO_MAIN];
   assign shared_sink_two_main_o = gen[led_port_pkg::BIT_TWO_TO_MAIN];
   assign aux_level_o = regs_q[led_port_pkg::IDX_AUX][led_port_pkg::AUX_LVL_W-1:0];
   assign indicator_level_o = regs_q[led_port_pkg::IDX_IND][led_port_pkg::AUX_LVL_W-1:0];

   // ------------------------------------------------------------
   // headroom shortfall persistence
   // ------------------------------------------------------------
   logic [TW-1:0] hdr_cnt_q;
   logic gain_q;
   wire logic [TW-1:0] hdr_delay = (hdr_sel == 2'h0) ? TW'(HDR_DELAY0_CYC)
                                 : (hdr_sel == 2'h1) ? TW'(HDR_DELAY1_CYC)
                                 : (hdr_sel == 2'h2) ? TW'(HDR_DELAY2_CYC)
                                 : TW'(led_port_pkg::HDR_C3);
   wire logic hdr_hit = (hdr_cnt_q == hdr_delay - TW'(1));

   // shortfall counter; a register write re-evaluates, set wins
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         hdr_cnt_q <= '0;
         gain_q <= 1'b0;
      end else begin
         hdr_cnt_q <= (!hdr_s || !run_s) ? '0 : hdr_hit ? hdr_cnt_q : hdr_cnt_q + TW'(1);
         gain_q <= run_s && ((hdr_s && hdr_hit) || (gain_q && !wr_fire));
      end
   end

   assign gain_boost_o = gain_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   start_enter_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      run_s && start_det |=> state_q == led_port_pkg::ST_RECV && bit_cnt_q == 4'h0 && byte_idx_q == 2'h0)
      else $error("start did not restart address reception");

   stop_idle_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      stop_det |=> state_q == led_port_pkg::ST_IDLE && !sda_oe_o)
      else $error("stop did not free the bus");

   ack_hold_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      $rose(sda_oe_o) |-> $past(byte_done) ##0
      (sda_oe_o throughout (##[1:1000] (scl_fall || !run_s || start_det || stop_det))))
      else $error("acknowledge not held through ninth pulse");

   addr_nack_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      state_q == led_port_pkg::ST_ACK && byte_idx_q == 2'h0 && !addr_hit |-> !sda_oe_o)
      else $error("foreign address acknowledged");

   byte_len_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      $rose(state_q == led_port_pkg::ST_ACK) |-> $past(bit_cnt_q) == led_port_pkg::BITS_PER_BYTE)
      else $error("byte not eight bits long");

   write_land_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      run_s && wr_fire && sel_q == led_port_pkg::REG_OFS[led_port_pkg::IDX_GENERAL] |=>
      gen == ($past(shift_q) & led_port_pkg::REG_WMASK[led_port_pkg::IDX_GENERAL]))
      else $error("general register write lost");

   hw_reset_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !run_s |=> gen == led_port_pkg::REG_RST[led_port_pkg::IDX_GENERAL] && !aux_on_q && !main_on_q && !ind_on_q)
      else $error("pin low left registers or sinks active");

   shared_off_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      one_on_q || two_on_q |->
      !($past(gen[led_port_pkg::BIT_ONE_OFF]) && one_on_q) && !($past(gen[led_port_pkg::BIT_TWO_OFF]) && two_on_q))
      else $error("shut down shared sink is on");

   shared_route_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      one_on_q |-> ($past(gen[led_port_pkg::BIT_ONE_TO_MAIN]) ? $past(main_on_d) : $past(aux_on_d)))
      else $error("shared sink not following its group");

   gain_delay_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      $rose(gain_boost_o) |-> $past(hdr_cnt_q) == $past(hdr_delay) - TW'(1))
      else $error("gain raised before shortfall persisted");

endmodule : led_reg_port

`default_nettype wire

// ==== design/level_ramp.sv ====
// stepping ramp of the main group brightness level
`timescale 1ns/100ps
`default_nettype none

module level_ramp #(
   parameter int LEVEL_W = 5,
   parameter int CNT_W = 21
) (
   input wire logic clk_i,                       // system clock
   input wire logic reset_i,                     // async reset, high
   input wire logic clear_i,                     // hardware pin held low
   input wire logic enable_i,                    // group enable
   input wire logic [LEVEL_W-1:0] target_i,      // target level
   input wire logic [CNT_W-1:0] step_cycles_i,   // cycles per step
   output logic [LEVEL_W-1:0] level_o,           // present level
   output logic active_o                         // group lit or ramping
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [LEVEL_W-1:0] level_q;
   logic [LEVEL_W-1:0] level_d;
   wire logic tick;
   wire logic [LEVEL_W-1:0] goal;
   wire logic settled;

   // ------------------------------------------------------------
   // step timing
   // ------------------------------------------------------------
   assign goal = enable_i ? target_i : '0;
   assign settled = (level_q == goal);
   assign tick = (cnt_q == step_cycles_i - CNT_W'(1));
   assign cnt_d = (clear_i || settled || tick) ? '0 : cnt_q + CNT_W'(1);
   // one level per step toward the goal
   assign level_d = clear_i ? '0
                  : (tick && level_q < goal) ? level_q + LEVEL_W'(1)
                  : (tick && level_q > goal) ? level_q - LEVEL_W'(1)
                  : level_q;
   assign level_o = level_q;
   assign active_o = enable_i | (level_q != '0);

   // step counter and level
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_q <= '0;
         level_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         level_q <= level_d;
      end
   end

   ramp_step_a: assert property (
      @(posedge clk_i) disable iff (reset_i)
      $changed(level_q) && !$past(clear_i) |-> $past(tick))
      else $error("level moved without a step tick");

endmodule : level_ramp

`default_nettype wire

// ==== tb/i2c_host_model.sv ====
// serial bus master model driving the register port
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model (
   input wire logic clk_i,  // system clock
   input wire logic sda_i,  // resolved data line
   output logic scl_o,      // serial clock, high when idle
   output logic sda_low_o   // high pulls the data line low
);
   // ---------------------------------
   // bus cycles, stepped on falling clock edges
   // ---------------------------------
   // released bus, clock stands still high
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // waits n falling clock edges
   task automatic idle(input int n);
      repeat (n) @(negedge clk_i);
   endtask : idle
   // first or repeated start, leaves clock low
   task automatic start_c();
      sda_low_o = 1'b0;
      idle(4);
      scl_o = 1'b1;
      idle(4);
      sda_low_o = 1'b1;
      idle(4);
      scl_o = 1'b0;
   endtask : start_c
   // stop condition, then bus idle
   task automatic stop_c();
      idle(1);
      sda_low_o = 1'b1;
      idle(3);
      scl_o = 1'b1;
      idle(4);
      sda_low_o = 1'b0;
      idle(4);
   endtask : stop_c
   // eight bits msb first, then the acknowledge slot
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         idle(1);
         sda_low_o = ~b[i];
         idle(3);
         scl_o = 1'b1;
         idle(4);
         scl_o = 1'b0;
      end
      idle(1);
      sda_low_o = 1'b0;
      idle(3);
      scl_o = 1'b1;
      idle(2);
      ack = ~sda_i;
      idle(2);
      scl_o = 1'b0;
   endtask : send_byte
   // whole write: address byte, register byte, data byte
   task automatic write3(input logic [7:0] dev, input logic [7:0] ofs, input logic [7:0] dat,
                         output logic [2:0] acks);
      start_c();
      send_byte(dev, acks[2]);
      send_byte(ofs, acks[1]);
      send_byte(dat, acks[0]);
      stop_c();
   endtask : write3
endmodule : i2c_host_model
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench of the led driver serial register port
`timescale 1ns/100ps
`default_nettype none
module tb;
   typedef struct packed {
      logic [7:0] dev;
      logic [7:0] ofs;
      logic [7:0] dat;
      logic [2:0] acks;
      logic [11:0] obs;
   } row_s;
   logic clk = 1'b0, reset = 1'b1, hw_pin = 1'b1, headroom_low = 1'b0;
   logic scl, sda_low, sda_oe, sda_drv, gain, main_on, aux_on, ind_on, one_on, one_main, two_on, two_main;
   logic [4:0] main_level;
   logic [2:0] aux_level, ind_level, acks;
   int mismatches = 0, n_compared = 0;
   // open-drain data line with pull-up
   wire logic sda_line = ~(sda_low | (sda_oe & ~sda_drv));
   wire logic [11:0] obs = {two_main, one_main, two_on, one_on, ind_on, aux_on, aux_level, ind_level};
   // writes and the outputs they should leave
   row_s rows [9] = '{'{8'h6c, 8'hb0, 8'hff, 3'b111, 12'h038}, '{8'h6c, 8'hc0, 8'h05, 3'b111, 12'h03d},
      '{8'h6c, 8'h10, 8'h06, 3'b111, 12'h3fd}, '{8'h6c, 8'h10, 8'hca, 3'b111, 12'h87d},
      '{8'h6c, 8'h10, 8'h12, 3'b111, 12'h17d}, '{8'h6c, 8'h30, 8'hff, 3'b111, 12'h17d},
      '{8'h6e, 8'hb0, 8'h00, 3'b000, 12'h17d}, '{8'h6d, 8'hb0, 8'h00, 3'b100, 12'h17d},
      '{8'h6c, 8'hb0, 8'h02, 3'b111, 12'h155}};
   always #25 clk = ~clk;
   // ---------------------------------
   // design and bus master
   // ---------------------------------
   led_reg_port #(.RAMP_STEP1_CYC(20), .RAMP_STEP2_CYC(40), .RAMP_STEP3_CYC(80), .HDR_DELAY0_CYC(40),
      .HDR_DELAY1_CYC(30)) led_reg_port_inst (.clk_i(clk), .reset_i(reset),
      .hardware_reset_pin_i(hw_pin), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_drv), .sda_oe_o(sda_oe),
      .headroom_low_i(headroom_low), .gain_boost_o(gain), .main_sinks_on_o(main_on), .main_level_o(main_level),
      .aux_sinks_on_o(aux_on), .aux_level_o(aux_level), .indicator_sink_on_o(ind_on),
      .indicator_level_o(ind_level), .shared_sink_one_on_o(one_on), .shared_sink_one_main_o(one_main),
      .shared_sink_two_on_o(two_on), .shared_sink_two_main_o(two_main));
   i2c_host_model i2c_host_model_inst (.clk_i(clk), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));
   // compares and counts
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // verdict and end of run
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run
   // watchdog against a hung bus
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      complete_run();
   end
   // ---------------------------------
   // main sequence
   // ---------------------------------
   initial begin
      repeat (16) @(negedge clk);
      reset = 1'b0;
      repeat (4) @(negedge clk);
      check(obs, 12'h000);
      foreach (rows[k]) begin
         i2c_host_model_inst.write3(rows[k].dev, rows[k].ofs, rows[k].dat, acks);
         check(12'(acks), 12'(rows[k].acks));
         check(obs, rows[k].obs);
      end
      // partial transfer cut by a repeated start
      i2c_host_model_inst.start_c();
      i2c_host_model_inst.send_byte(8'h6c, acks[2]);
      i2c_host_model_inst.send_byte(8'hc0, acks[1]);
      i2c_host_model_inst.write3(8'h6c, 8'hb0, 8'h06, acks);
      check(obs, 12'h175);
      // main group ramps up at 20 cycles a step
      i2c_host_model_inst.write3(8'h6c, 8'h20, 8'h01, acks);
      i2c_host_model_inst.write3(8'h6c, 8'ha0, 8'h03, acks);
      i2c_host_model_inst.write3(8'h6c, 8'h10, 8'h01, acks);
      repeat (100) @(negedge clk);
      check(12'({main_on, main_level}), 12'h023);
      // shortfall shorter than 40 cycles is ignored, longer one boosts
      headroom_low = 1'b1;
      repeat (30) @(negedge clk);
      check(12'(gain), 12'h000);
      repeat (30) @(negedge clk);
      check(12'(gain), 12'h001);
      headroom_low = 1'b0;
      i2c_host_model_inst.write3(8'h6c, 8'h60, 8'h03, acks);
      check(12'(gain), 12'h000);
      // delay code 01 waits 30 cycles
      i2c_host_model_inst.write3(8'h6c, 8'h60, 8'h01, acks);
      headroom_low = 1'b1;
      repeat (25) @(negedge clk);
      check(12'(gain), 12'h000);
      repeat (15) @(negedge clk);
      check(12'(gain), 12'h001);
      headroom_low = 1'b0;
      // disabled main group ramps down at 40 cycles a step
      i2c_host_model_inst.write3(8'h6c, 8'h20, 8'h02, acks);
      i2c_host_model_inst.write3(8'h6c, 8'h10, 8'h00, acks);
      repeat (60) @(negedge clk);
      check(12'({main_on, main_level}), 12'h022);
      repeat (80) @(negedge clk);
      check(12'({main_on, main_level}), 12'h000);
      // hardware pin low clears registers and outputs
      hw_pin = 1'b0;
      repeat (6) @(negedge clk);
      check({obs[11:1], main_on}, 12'h000);
      hw_pin = 1'b1;
      repeat (6) @(negedge clk);
      complete_run();
   end
endmodule : tb
`default_nettype wire
